//--- common/sltr_pkg.sv
package sltr_pkg;

    // ---------------------------------------------------------------
    // Geometry
    // ---------------------------------------------------------------
    localparam int unsigned QUAD_COUNT     = 12;
    localparam int unsigned LANES_PER_QUAD = 4;
    localparam int unsigned ADDR_W         = 8;
    localparam int unsigned DATA_W         = 32;

    // ---------------------------------------------------------------
    // Register map: byte address = quad number * 16 + register offset * 4
    // ---------------------------------------------------------------
    localparam logic [1:0] OFF_XCVR_CTL   = 2'h0; // transceiver_control
    localparam logic [1:0] OFF_TX_UPPER   = 2'h1; // tx_driver_level_upper
    localparam logic [1:0] OFF_RX_EQ      = 2'h2; // rx_equalization_lane_ctl
    localparam logic [3:0] QUAD_GAP_FIRST = 4'ha; // quads 10, 11 absent
    localparam logic [3:0] QUAD_GAP_LAST  = 4'hb;
    localparam logic [3:0] QUAD_LAST      = 4'hd;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int unsigned LANE_SEL_LSB   = 0;  // lane_select [3:0]
    localparam int unsigned FINE_DE_LSB    = 21; // [23:21]
    localparam int unsigned LS_G1_LSB      = 24; // [27:24]
    localparam int unsigned LS_G2_LSB      = 28; // [31:28]
    localparam int unsigned EQ_ZERO_LSB    = 0;  // [2:0]
    localparam int unsigned EQ_BOOST_LSB   = 3;  // [5:3]

    // ---------------------------------------------------------------
    // Reset values
    // ---------------------------------------------------------------
    localparam logic [3:0] LANE_SEL_RST = 4'hf;
    localparam logic [2:0] FINE_DE_RST  = 3'h2;
    localparam logic [3:0] LS_G1_RST    = 4'h9;
    localparam logic [3:0] LS_G2_RST    = 4'h8;
    localparam logic [2:0] EQ_ZERO_RST  = 3'h1;
    localparam logic [2:0] EQ_BOOST_RST = 3'h7;

    // Stored tuning of one lane
    typedef struct packed {
        logic [3:0] lowSwingG2;
        logic [3:0] lowSwingG1;
        logic [2:0] fineDeemph6dbG2;
        logic [2:0] eqBoost;
        logic [2:0] eqZero;
    } sltr_store_t;

    // Effective settings handed to one lane's analog front end
    typedef struct packed {
        logic       fineDeemphValid;
        logic [2:0] fineDeemph;
        logic       lowSwingValid;
        logic [3:0] lowSwingLevel;
        logic       eqEnable;
        logic [2:0] eqZero;
        logic [2:0] eqBoost;
    } sltr_lane_t;

endpackage

//--- core/sltr_lane_tuning_regs.sv
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none

module sltr_lane_tuning_regs
    import sltr_pkg::*;
#(
    parameter int unsigned QUADS = QUAD_COUNT,
    parameter int unsigned LANES = LANES_PER_QUAD
) (
    // Clock and resets
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          stickyRst,
    // Register port
    input  wire logic [ADDR_W-1:0]             regAddr,
    input  wire logic [DATA_W-1:0]             regWrData,
    input  wire logic                          regWrite,
    input  wire logic                          regRead,
    output logic      [DATA_W-1:0]             regRdData,
    // Per-quad port state
    input  wire logic [QUADS-1:0]              lowSwingEnable,
    input  wire logic [QUADS-1:0]              gen2Rate,
    input  wire logic [QUADS-1:0]              deemphasisSelect,
    // Per-lane effective tuning
    output sltr_lane_t [QUADS*LANES-1:0]       laneTuning
);

    localparam int unsigned TOTAL = QUADS * LANES;

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------

    // Quad number to storage slot; quads 10 and 11 do not exist
    function automatic logic [3:0] quadSlot(input logic [3:0] q);
        if (q > QUAD_GAP_LAST) begin
            return 4'(q - 4'h2);
        end
        return q;
    endfunction

    // A quad number that has registers behind it
    function automatic logic quadExists(input logic [3:0] q);
        return (q < QUAD_GAP_FIRST)
            || ((q > QUAD_GAP_LAST) && (q <= QUAD_LAST));
    endfunction

    // Lowest lane set in a lane-select mask, zero when empty
    function automatic logic [1:0] firstLane(input logic [3:0] mask);
        logic [1:0] pick;
        pick = 2'h0;
        for (int i = LANES - 1; i >= 0; i--) begin
            if (mask[i]) begin
                pick = 2'(i);
            end
        end
        return pick;
    endfunction

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    logic [3:0]  quadNum;
    logic [1:0]  regOff;
    logic        hit;
    logic [3:0]  slot;

    assign quadNum = regAddr[7:4];
    assign regOff  = regAddr[3:2];
    assign hit     = quadExists(quadNum) && (regAddr[1:0] == 2'h0);
    assign slot    = quadSlot(quadNum);

    // ---------------------------------------------------------------
    // Storage
    // ---------------------------------------------------------------
    logic [3:0]   lane_select_reg [QUADS];
    sltr_store_t  tune_reg    [TOTAL];

    // Lane select is ordinary control state, set to all lanes (4'hf) by plain reset
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int q = 0; q < QUADS; q++) begin
                lane_select_reg[q] <= LANE_SEL_RST;
            end
        end else if (regWrite && hit && regOff == OFF_XCVR_CTL) begin
            lane_select_reg[slot] <= regWrData[LANE_SEL_LSB +: 4];
        end
    end

    // Tuning fields: only the sticky reset touches them, so a link or
    // hot reset keeps whatever software trimmed in
    always_ff @(posedge clk) begin
        if (stickyRst) begin
            for (int l = 0; l < TOTAL; l++) begin
                tune_reg[l].fineDeemph6dbG2 <= FINE_DE_RST;
                tune_reg[l].lowSwingG1      <= LS_G1_RST;
                tune_reg[l].lowSwingG2      <= LS_G2_RST;
                tune_reg[l].eqZero          <= EQ_ZERO_RST;
                tune_reg[l].eqBoost         <= EQ_BOOST_RST;
            end
        end else if (regWrite && hit) begin
            for (int k = 0; k < LANES; k++) begin
                if (lane_select_reg[slot][k]) begin
                    if (regOff == OFF_TX_UPPER) begin
                        tune_reg[slot*LANES+k].fineDeemph6dbG2 <=
                            regWrData[FINE_DE_LSB +: 3];
                        tune_reg[slot*LANES+k].lowSwingG1 <=
                            regWrData[LS_G1_LSB +: 4];
                        tune_reg[slot*LANES+k].lowSwingG2 <=
                            regWrData[LS_G2_LSB +: 4];
                    end else if (regOff == OFF_RX_EQ) begin
                        tune_reg[slot*LANES+k].eqZero <=
                            regWrData[EQ_ZERO_LSB +: 3];
                        tune_reg[slot*LANES+k].eqBoost <=
                            regWrData[EQ_BOOST_LSB +: 3];
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    sltr_store_t  readLane;
    logic [31:0]  readWord;

    // Selected lane view; a multi-lane mask shows its lowest lane
    assign readLane =
        tune_reg[slot*LANES + 32'(firstLane(lane_select_reg[slot]))];

    // Unmapped addresses and reserved bits read as zero
    always_comb begin
        readWord = 32'h0;
        if (hit) begin
            case (regOff)
                OFF_XCVR_CTL: begin
                    readWord[LANE_SEL_LSB +: 4] = lane_select_reg[slot];
                end
                OFF_TX_UPPER: begin
                    readWord[FINE_DE_LSB +: 3] = readLane.fineDeemph6dbG2;
                    readWord[LS_G1_LSB +: 4]   = readLane.lowSwingG1;
                    readWord[LS_G2_LSB +: 4]   = readLane.lowSwingG2;
                end
                OFF_RX_EQ: begin
                    readWord[EQ_ZERO_LSB +: 3]  = readLane.eqZero;
                    readWord[EQ_BOOST_LSB +: 3] = readLane.eqBoost;
                end
                default: begin
                    readWord = 32'h0;
                end
            endcase
        end
    end

    // Data stands for the cycle after the strobe only
    always_ff @(posedge clk) begin
        if (rst) begin
            regRdData <= 32'h0;
        end else if (regRead) begin
            regRdData <= readWord;
        end else begin
            regRdData <= 32'h0;
        end
    end

    // ---------------------------------------------------------------
    // Effective lane settings
    // ---------------------------------------------------------------
    sltr_lane_t laneNext [TOTAL];

    // Mode steering per lane; codes not in use are driven as zero so the
    // front end never acts on a stale value
    always_comb begin
        for (int l = 0; l < TOTAL; l++) begin
            laneNext[l] = '0;
            // Low swing turns de-emphasis off entirely
            laneNext[l].fineDeemphValid = !lowSwingEnable[l/LANES]
                && gen2Rate[l/LANES] && deemphasisSelect[l/LANES];
            if (laneNext[l].fineDeemphValid) begin
                laneNext[l].fineDeemph = tune_reg[l].fineDeemph6dbG2;
            end
            laneNext[l].lowSwingValid = lowSwingEnable[l/LANES];
            if (lowSwingEnable[l/LANES]) begin
                laneNext[l].lowSwingLevel = gen2Rate[l/LANES]
                    ? tune_reg[l].lowSwingG2
                    : tune_reg[l].lowSwingG1;
            end
            laneNext[l].eqZero   = tune_reg[l].eqZero;
            laneNext[l].eqBoost  = tune_reg[l].eqBoost;
            laneNext[l].eqEnable = (tune_reg[l].eqZero != 3'h0)
                || (tune_reg[l].eqBoost != 3'h0);
        end
    end

    // Registered hand-off to the lanes
    always_ff @(posedge clk) begin
        if (rst) begin
            laneTuning <= '0;
        end else begin
            for (int l = 0; l < TOTAL; l++) begin
                laneTuning[l] <= laneNext[l];
            end
        end
    end

endmodule

`default_nettype wire

//--- verification/sltr_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------------------------------------
// Port checker; lane 0 of slot 0 stands in for every lane
// ---------------------------------------------------------------
module sltr_monitor
    import sltr_pkg::*;
#(
    parameter int unsigned QUADS = QUAD_COUNT,
    parameter int unsigned LANES = LANES_PER_QUAD
) (
    // Clock and reset
    input wire logic                         clk,
    input wire logic                         rst,
    // Register port
    input wire logic [ADDR_W-1:0]            regAddr,
    input wire logic                         regWrite,
    input wire logic                         regRead,
    input wire logic [DATA_W-1:0]            regRdData,
    // Port state and lane outputs
    input wire logic [QUADS-1:0]             lowSwingEnable,
    input wire logic [QUADS-1:0]             gen2Rate,
    input wire logic [QUADS-1:0]             deemphasisSelect,
    input wire sltr_lane_t [QUADS*LANES-1:0] laneTuning
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Outputs lag port state by one edge, so the first edge is skipped
    a_fine_full_swing: assert property (!$past(rst) |->
        laneTuning[0].fineDeemphValid == $past(!lowSwingEnable[0] &&
        gen2Rate[0] && deemphasisSelect[0])) else $error("fine valid");
    a_fine_off_zero: assert property (!laneTuning[0].fineDeemphValid
        |-> laneTuning[0].fineDeemph == 3'h0) else $error("fine code");
    a_low_swing_follow: assert property (!$past(rst) |->
        laneTuning[0].lowSwingValid == $past(lowSwingEnable[0]))
        else $error("low swing valid");
    a_level_off_zero: assert property (!laneTuning[0].lowSwingValid
        |-> laneTuning[0].lowSwingLevel == 4'h0) else $error("level");
    a_eq_off_both: assert property (laneTuning[0].eqEnable ==
        (laneTuning[0].eqZero != 3'h0 || laneTuning[0].eqBoost != 3'h0))
        else $error("eq enable");
    a_rd_idle_zero: assert property (!$past(regRead) |->
        regRdData == 32'h0) else $error("idle read data");
    a_tx_low_zero: assert property ($past(regRead) &&
        $past(regAddr[3:0]) == 4'h4 |-> regRdData[20:0] == 21'h0)
        else $error("tx low bits");
    a_eq_reserved: assert property ($past(regRead) &&
        $past(regAddr[3:0]) == 4'h8 |-> regRdData[31:6] == 26'h0)
        else $error("eq reserved");
    a_quad_absent: assert property ($past(regRead) &&
        $past(regAddr[7:4]) inside {4'ha, 4'hb, 4'he, 4'hf}
        |-> regRdData == 32'h0) else $error("absent quad");
    c_write: cover property (regWrite);
    c_read: cover property (regRead ##1 regRdData != 32'h0);
    c_eq_off: cover property ($fell(laneTuning[0].eqEnable));
endmodule

bind sltr_lane_tuning_regs sltr_monitor #(.QUADS(QUADS), .LANES(LANES))
    sltr_monitor_inst (.clk(clk), .rst(rst), .regAddr(regAddr),
    .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .lowSwingEnable(lowSwingEnable), .gen2Rate(gen2Rate),
    .deemphasisSelect(deemphasisSelect), .laneTuning(laneTuning));
`default_nettype wire

//--- verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    import sltr_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus and instance
    // ---------------------------------------------------------------
    logic                 clk, rst, stickyRst, regWrite, regRead;
    logic [7:0]           regAddr;
    logic [31:0]          regWrData, regRdData;
    logic [11:0]          lowSwingEnable, gen2Rate, deemphasisSelect;
    sltr_lane_t [47:0]    laneTuning;
    int                   errors = 0, n_checks = 0;
    sltr_lane_tuning_regs sltr_lane_tuning_regs_inst (.clk(clk),
        .rst(rst), .stickyRst(stickyRst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
        .regRdData(regRdData), .lowSwingEnable(lowSwingEnable),
        .gen2Rate(gen2Rate), .deemphasisSelect(deemphasisSelect),
        .laneTuning(laneTuning));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Bus cycles; strobes drop at the edge that takes them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        `CHK(regRdData, e)
    endtask
    // Lane outputs need one edge after a write or a port change; settle waits two
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks=%0d errors=%0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_defaults;
        rdc(8'h00, 32'hf);
        rdc(8'h04, 32'h89400000);
        rdc(8'h08, 32'h39);
        `CHK(laneTuning[0].fineDeemph, 3'h2)
        `CHK(laneTuning[5].eqZero, 3'h1)
        $display("test defaults done");
    endtask
    task automatic t_lanes;
        wr(8'h00, 32'h2);
        wr(8'h04, 32'h35c00000);
        rdc(8'h04, 32'h35c00000);
        wr(8'h00, 32'h1);
        rdc(8'h04, 32'h89400000);
        lowSwingEnable <= 12'h001;
        settle();
        `CHK(laneTuning[1].lowSwingLevel, 4'h3)
        `CHK(laneTuning[0].lowSwingLevel, 4'h8)
        `CHK(laneTuning[1].fineDeemphValid, 1'b0)
        gen2Rate <= 12'hffe;
        settle();
        `CHK(laneTuning[1].lowSwingLevel, 4'h5)
        lowSwingEnable <= 12'h000;
        $display("test lanes done");
    endtask
    task automatic t_equalizer;
        wr(8'hc0, 32'h8);
        wr(8'hc8, 32'h0);
        settle();
        `CHK(laneTuning[43].eqEnable, 1'b0)
        `CHK(laneTuning[40].eqEnable, 1'b1)
        rdc(8'hc8, 32'h0);
        wr(8'hc0, 32'h1);
        rdc(8'hc8, 32'h39);
        wr(8'h98, 32'hffffffff);
        rdc(8'h98, 32'h3f);
        wr(8'ha8, 32'h3f);
        rdc(8'ha8, 32'h0);
        rdc(8'h0c, 32'h0);
        $display("test equalizer done");
    endtask
    task automatic t_sticky;
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        wr(8'h00, 32'h2);
        rdc(8'h04, 32'h35c00000);
        stickyRst <= 1'b1;
        @(posedge clk);
        stickyRst <= 1'b0;
        rdc(8'h04, 32'h89400000);
        $display("test sticky done");
    endtask
    // Both resets together at power-up, then the scenarios in turn
    initial begin
        {rst, stickyRst, regWrite, regRead} = 4'hc;
        regAddr = 8'h0;
        regWrData = 32'h0;
        lowSwingEnable = 12'h000;
        gen2Rate = 12'hfff;
        deemphasisSelect = 12'h001;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        stickyRst <= 1'b0;
        settle();
        t_defaults();
        t_lanes();
        t_equalizer();
        t_sticky();
        end_of_test();
    end
    // Whole run is about sixty cycles; this is far beyond it
    initial begin
        #200000;
        errors++;
        end_of_test();
    end
endmodule
`default_nettype wire
